// ===== core/clvo_pkg.sv
// package: constants, types and checks for the video link output formatter
package clvo_pkg;
    localparam int unsigned LANE_MAX = 10;             // widest lane set
    localparam int unsigned SAMPLE_W = 16;             // sample word width
    // register byte offsets
    localparam logic [3:0] OFS_SETUP = 4'h0;           // stored lane/clock/mirror settings
    localparam logic [3:0] OFS_FORMAT = 4'h4;          // sample width and wide range
    localparam logic [3:0] OFS_STATUS = 4'h8;          // settings in force
    // field positions
    localparam int SETUP_LANES_LSB = 0;                // [3:0] lane count
    localparam int SETUP_CLK_LSB = 4;                  // [10:4] pixel clock in MHz
    localparam int SETUP_MIRH_BIT = 12;                // horizontal mirror
    localparam int SETUP_MIRV_BIT = 13;                // vertical mirror
    localparam int FMT_DEPTH_LSB = 0;                  // [4:0] sample width
    localparam int FMT_WDR_BIT = 8;                    // wide dynamic range enable
    localparam int STAT_CFG_LSB = 16;                  // [17:16] link configuration
    localparam int STAT_BAYER_LSB = 20;                // [21:20] bayer phase
    // legal values and reset values
    localparam logic [6:0] CLK_45 = 7'h2D;
    localparam logic [6:0] CLK_65 = 7'h41;
    localparam logic [6:0] CLK_85 = 7'h55;
    localparam logic [3:0] LANES_RESET = 4'h1;
    localparam logic [6:0] CLK_RESET = CLK_85;
    localparam logic [4:0] DEPTH_RESET = 5'h08;
    localparam int SCALE_SHIFT = 2;                    // times four on wide lane sets
    localparam int SIG_BITS_NO_WDR = 12;               // meaningful bits without wide range

    typedef enum logic [1:0] {CFG_BASE = 2'b00, CFG_MEDIUM = 2'b01, CFG_FULL = 2'b10, CFG_80BIT = 2'b11} clvo_config_t;
    typedef enum logic [1:0] {BAY_RGGB = 2'b00, BAY_GBRG = 2'b01, BAY_GRBG = 2'b10, BAY_BGGR = 2'b11} clvo_bayer_t;
    typedef enum logic {BUS_IDLE = 1'b0, BUS_ACK = 1'b1} clvo_bus_state_t;

    typedef struct packed {logic [15:0] sample; logic sof; logic eol; logic eof;} clvo_pixel_t;
    typedef struct packed {logic fval; logic lval; logic dval;} clvo_sync_t;
    typedef struct packed {logic [3:0] lanes; logic [6:0] clk_mhz; logic mir_h; logic mir_v;} clvo_setup_t;

    // lane counts the link supports
    function automatic logic clvo_lanes_ok(input logic [3:0] l);
        return (l == 4'h1) || (l == 4'h2) || (l == 4'h3) || (l == 4'h4) || (l == 4'h8) || (l == 4'hA);
    endfunction : clvo_lanes_ok

    // pixel clock choices
    function automatic logic clvo_clk_ok(input logic [6:0] c);
        return (c == CLK_45) || (c == CLK_65) || (c == CLK_85);
    endfunction : clvo_clk_ok

    // sample widths allowed for a lane count
    function automatic logic clvo_depth_ok(input logic [4:0] d, input logic [3:0] l);
        return (d == 5'h08) || (((d == 5'h0A) || (d == 5'h0C)) && ((l == 4'h1) || (l == 4'h2) || (l == 4'h4)))
            || ((d == 5'h10) && (l == 4'h1));
    endfunction : clvo_depth_ok
endpackage : clvo_pkg

// ===== core/clvo_link_out.sv
// video link output formatter: settings, lane packing, link timing and register slave
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module clvo_link_out
    import clvo_pkg::*;
(
    input wire logic clock_in,                               // 100 MHz block clock
    input wire logic reset_in,                               // restart, synchronous, active high
    input wire logic power_on_reset_in,                      // first power-up, clears stored settings
    // avalon-mm slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // sensor pixel stream
    input wire logic pix_valid_in,
    input wire clvo_pixel_t pix_in,
    output logic pix_ready_out,
    // link side
    input wire logic link_clk_in,                            // pixel clock back from the clock generator
    output logic [6:0] pclk_mhz_out,                         // frequency request to the clock generator
    output clvo_config_t link_config_out,
    output clvo_bayer_t bayer_phase_out,
    output logic [LANE_MAX*SAMPLE_W-1:0] lane_data_out,
    output clvo_sync_t link_sync_out
);

    ////////////////////////////////////////////////////////////////////////////
    // settings: stored copy and copy in force

    clvo_setup_t nv_q;                                       // survives restart, only power-up clears
    clvo_setup_t act_q;                                      // in force since last restart
    logic [4:0] depth_q;                                     // sample width, immediate
    logic wdr_q;                                             // wide dynamic range enable

    // bus decode
    clvo_bus_state_t bus_q;
    logic [31:0] rdata_q;
    wire bus_req = avs_read_in | avs_write_in;
    wire bus_done = bus_req & (bus_q == BUS_ACK);
    wire full_word = (avs_byteenable_in == 4'hF);
    wire wr_commit = bus_done & avs_write_in & full_word;
    wire sel_setup = (avs_address_in == OFS_SETUP);
    wire sel_format = (avs_address_in == OFS_FORMAT);
    wire sel_status = (avs_address_in == OFS_STATUS);

    // candidate values from write data
    wire [3:0] wr_lanes = avs_writedata_in[SETUP_LANES_LSB +: 4];
    wire [6:0] wr_clk = avs_writedata_in[SETUP_CLK_LSB +: 7];
    wire [4:0] wr_depth = avs_writedata_in[FMT_DEPTH_LSB +: 5];
    wire setup_ok = clvo_lanes_ok(wr_lanes) & clvo_clk_ok(wr_clk);
    wire setup_take = wr_commit & sel_setup & setup_ok;
    wire format_take = wr_commit & sel_format & clvo_depth_ok(wr_depth, act_q.lanes);

    // stored settings: write lands here and waits for restart, no save command
    always_ff @(posedge clock_in) begin
        if (power_on_reset_in) begin
            nv_q <= '{lanes: LANES_RESET, clk_mhz: CLK_RESET, mir_h: 1'b0, mir_v: 1'b0};
        end else if (setup_take) begin
            nv_q <= '{lanes: wr_lanes, clk_mhz: wr_clk,
                      mir_h: avs_writedata_in[SETUP_MIRH_BIT], mir_v: avs_writedata_in[SETUP_MIRV_BIT]};
        end
    end

    // settings in force: only a restart copies the stored set
    always_ff @(posedge clock_in) begin
        if (power_on_reset_in) begin
            act_q <= '{lanes: LANES_RESET, clk_mhz: CLK_RESET, mir_h: 1'b0, mir_v: 1'b0};
        end else if (reset_in) begin
            act_q <= nv_q;
        end
    end

    // sample width: back to eight on restart so it is always legal for the lanes
    always_ff @(posedge clock_in) begin
        if (reset_in | power_on_reset_in) begin
            depth_q <= DEPTH_RESET;
            wdr_q <= 1'b0;
        end else if (format_take) begin
            depth_q <= wr_depth;
            wdr_q <= avs_writedata_in[FMT_WDR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle, answer on the second edge

    clvo_config_t cfg;
    always_comb begin
        case (act_q.lanes)
            4'h4: cfg = CFG_MEDIUM;
            4'h8: cfg = CFG_FULL;
            4'hA: cfg = CFG_80BIT;
            default: cfg = CFG_BASE;
        endcase
    end
    wire clvo_bayer_t bayer = clvo_bayer_t'({act_q.mir_h, act_q.mir_v});

    wire [31:0] rd_setup = {18'h00000, nv_q.mir_v, nv_q.mir_h, 1'b0, nv_q.clk_mhz, nv_q.lanes};
    wire [31:0] rd_format = {23'h000000, wdr_q, 3'h0, depth_q};
    wire [31:0] rd_status = {10'h000, bayer, 2'h0, cfg, 5'h00, act_q.clk_mhz, act_q.lanes};
    wire [31:0] rd_mux = sel_setup ? rd_setup : sel_format ? rd_format : sel_status ? rd_status : 32'h00000000;

    // bus state: idle takes the request, ack releases waitrequest for one cycle
    always_ff @(posedge clock_in) begin
        if (reset_in | power_on_reset_in) begin
            bus_q <= BUS_IDLE;
            rdata_q <= 32'h00000000;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (bus_req) begin
                        bus_q <= BUS_ACK;
                    end
                    if (avs_read_in) begin
                        rdata_q <= rd_mux;                                           // unmapped reads zero
                    end
                end
                BUS_ACK: bus_q <= BUS_IDLE;
                default: bus_q <= BUS_IDLE;
            endcase
        end
    end
    assign avs_waitrequest_out = bus_req & (bus_q != BUS_ACK);
    assign avs_readdata_out = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // sample formatting

    wire wide_set = (act_q.lanes == 4'h8) || (act_q.lanes == 4'hA);
    // times four with saturation, so a bright pixel never wraps to dark
    wire [15:0] scaled = wide_set ? ((|pix_in.sample[15:14]) ? 16'hFFFF : {pix_in.sample[13:0], 2'b00})
                                  : pix_in.sample;
    // without wide range the low four bits of a sixteen-bit word carry nothing
    wire [15:0] masked = ((depth_q == 5'h10) && !wdr_q) ? {scaled[15:16-SIG_BITS_NO_WDR], 4'h0} : scaled;
    wire [4:0] drop = 5'h10 - depth_q;
    wire [15:0] fmt_sample = masked >> drop;                                         // lsb-aligned on the lane

    ////////////////////////////////////////////////////////////////////////////
    // link clock sampling: two flops, then edge detect on the second

    logic lclk_meta_q, lclk_sync_q, lclk_prev_q;
    always_ff @(posedge clock_in) begin
        if (reset_in | power_on_reset_in) begin
            lclk_meta_q <= 1'b0;
            lclk_sync_q <= 1'b0;
            lclk_prev_q <= 1'b0;
        end else begin
            lclk_meta_q <= link_clk_in;
            lclk_sync_q <= lclk_meta_q;
            lclk_prev_q <= lclk_sync_q;
        end
    end
    wire link_tick = lclk_sync_q & ~lclk_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // lane packing: consecutive pixels fill lanes 0..n-1, one group per tick

    logic [3:0] fill_q;                                      // next lane to fill
    logic group_full_q;
    logic grp_sof_q, grp_eof_q;
    logic frame_q;                                           // inside a frame
    logic [15:0] lane_q [LANE_MAX];
    logic [15:0] lane_out_q [LANE_MAX];
    clvo_sync_t sync_q;

    wire take_pixel = pix_valid_in & ~group_full_q;
    wire send_group = link_tick & group_full_q;
    wire last_lane = (fill_q == act_q.lanes - 4'h1);
    // stalls the sensor while a group waits for the link
    assign pix_ready_out = ~group_full_q & ~reset_in & ~power_on_reset_in;

    // fill counter and group flags
    always_ff @(posedge clock_in) begin
        if (reset_in | power_on_reset_in) begin
            fill_q <= 4'h0;
            group_full_q <= 1'b0;
            grp_sof_q <= 1'b0;
            grp_eof_q <= 1'b0;
        end else if (send_group) begin
            fill_q <= 4'h0;
            group_full_q <= 1'b0;
            grp_sof_q <= 1'b0;
            grp_eof_q <= 1'b0;
        end else if (take_pixel) begin
            fill_q <= last_lane ? 4'h0 : fill_q + 4'h1;
            group_full_q <= last_lane;
            grp_sof_q <= grp_sof_q | pix_in.sof;
            grp_eof_q <= grp_eof_q | pix_in.eof;
        end
    end

    // per-lane capture and output registers
    for (genvar k = 0; k < LANE_MAX; k++) begin : g_lane
        always_ff @(posedge clock_in) begin
            if (reset_in | power_on_reset_in) begin
                lane_q[k] <= 16'h0000;
                lane_out_q[k] <= 16'h0000;
            end else begin
                if (take_pixel && fill_q == 4'(k)) begin
                    lane_q[k] <= fmt_sample;
                end
                if (send_group) begin
                    lane_out_q[k] <= lane_q[k];
                end
            end
        end
        // lane k occupies the k-th port group in standard order
        assign lane_data_out[k*SAMPLE_W +: SAMPLE_W] = lane_out_q[k];
    end

    // frame and line flags, changed only on link ticks so the grabber sees a whole period
    always_ff @(posedge clock_in) begin
        if (reset_in | power_on_reset_in) begin
            sync_q <= '{fval: 1'b0, lval: 1'b0, dval: 1'b0};
            frame_q <= 1'b0;
        end else if (link_tick) begin
            sync_q.dval <= group_full_q;
            sync_q.lval <= group_full_q;
            sync_q.fval <= group_full_q ? (frame_q | grp_sof_q) : frame_q;
            if (group_full_q) begin
                frame_q <= (frame_q | grp_sof_q) & ~grp_eof_q;
            end
        end
    end

    assign link_sync_out = sync_q;
    assign link_config_out = cfg;
    assign bayer_phase_out = bayer;
    assign pclk_mhz_out = act_q.clk_mhz;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    lanes_in_set_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        clvo_lanes_ok(act_q.lanes)) else $error("lane count in force is not a legal value");

    clock_in_set_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        clvo_clk_ok(pclk_mhz_out)) else $error("pixel clock request is not 45, 65 or 85");

    bad_setup_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (wr_commit && sel_setup && !clvo_lanes_ok(wr_lanes)) |=> $stable(nv_q))
        else $error("illegal lane request changed stored settings");

    deferred_apply_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (setup_take && !reset_in) ##1 !reset_in |-> $stable(act_q) && nv_q.lanes == $past(wr_lanes))
        else $error("settings applied without restart or not stored");

    // eight-bit words are the only width wide lane sets allow, so the check uses them
    scale_four_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        (take_pixel && fill_q == 4'h0 && wide_set && depth_q == 5'h08 && pix_in.sample[15:14] == 2'b00)
        |=> lane_q[0] == {8'h00, $past(pix_in.sample[13:6])})
        else $error("wide lane set did not scale by four");

    depth_legal_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        clvo_depth_ok(depth_q, act_q.lanes)) else $error("sample width not allowed for lane count");

    config_map_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (act_q.lanes == 4'h4) == (link_config_out == CFG_MEDIUM)
        && (act_q.lanes == 4'hA) == (link_config_out == CFG_80BIT))
        else $error("link configuration does not follow lane count");

    no_wdr_mask_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        (take_pixel && fill_q == 4'h0 && depth_q == 5'h10 && !wdr_q) |=> lane_q[0][3:0] == 4'h0)
        else $error("low bits carried without wide range");

    bayer_map_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        $rose(act_q.mir_h) && !act_q.mir_v |-> bayer_phase_out == BAY_GRBG)
        else $error("bayer phase does not follow mirror bits");

    bus_answer_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        (bus_req && bus_q == BUS_IDLE) |=> !avs_waitrequest_out)
        else $error("bus request not answered on the second edge");

    // the answer lasts one cycle, then the slave is free for the next request
    ack_one_cycle_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        bus_q == BUS_ACK |=> bus_q == BUS_IDLE)
        else $error("bus answer held longer than one cycle");

    ////////////////////////////////////////////////////////////////////////////
    // restart behaviour of the two copies of the settings

    // a plain restart must never lose what was stored
    stored_kept_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (reset_in && !power_on_reset_in) |=> $stable(nv_q))
        else $error("restart changed stored settings");

    // a restart copies the stored set into force, mirrors included
    apply_copy_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (reset_in && !power_on_reset_in) |=> act_q == $past(nv_q))
        else $error("restart did not apply the stored settings");

    // width is not stored, so a restart falls back to eight bits
    depth_back_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        reset_in |=> depth_q == DEPTH_RESET && !wdr_q)
        else $error("sample width not back to eight after restart");

    ////////////////////////////////////////////////////////////////////////////
    // mirror phases with the vertical mirror set, not covered by the rising-edge check above

    both_mirror_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (act_q.mir_h && act_q.mir_v) |-> bayer_phase_out == BAY_BGGR)
        else $error("both mirrors do not give the fourth phase");

    vert_mirror_a: assert property (@(posedge clock_in) disable iff (power_on_reset_in)
        (!act_q.mir_h && act_q.mir_v) |-> bayer_phase_out == BAY_GBRG)
        else $error("vertical mirror alone gives the wrong phase");

    ////////////////////////////////////////////////////////////////////////////
    // stream side: stall and link timing

    // the last pixel of a group closes the door until the link takes it
    group_stall_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        (take_pixel && last_lane) |=> !pix_ready_out)
        else $error("sensor not stalled after a full group");

    // flags move only on a detected link edge, so the grabber sees whole periods
    sync_on_tick_a: assert property (@(posedge clock_in) disable iff (reset_in | power_on_reset_in)
        !link_tick |=> $stable(link_sync_out))
        else $error("link flags changed between link edges");

endmodule : clvo_link_out

// ===== test/clvo_grabber_model.sv
// grabber model: free-running link pixel clock and lane 0 capture
`timescale 1ns/1ns
module clvo_grabber_model
    import clvo_pkg::*;
(
    input wire logic [LANE_MAX*SAMPLE_W-1:0] lane_data_in,  // lanes from the formatter
    input wire clvo_sync_t link_sync_in,                     // frame, line and data valid
    output logic link_clk_out,                               // pll output, 80 ns period
    output logic [15:0] capture_out                          // last lane 0 word taken
);
    ////////////////////////////////////////////////////////////////////////
    // the pll output runs free, so it keeps toggling between frames
    initial link_clk_out = 1'b0;
    always #40 link_clk_out = ~link_clk_out;
    ////////////////////////////////////////////////////////////////////////
    // capture only on the link clock and only while data is flagged valid
    initial capture_out = 16'h0000;
    always @(posedge link_clk_out) begin
        if (link_sync_in.dval) begin
            capture_out <= lane_data_in[15:0];
        end
    end
endmodule : clvo_grabber_model

// ===== test/clvo_link_out_bench.sv
// bench: random and corner stimulus for the video link output formatter
`timescale 1ns/1ns
module camera_link_video_output_config_bench;
    import clvo_pkg::*;
    logic clock_in = 1'b0, reset_in = 1'b0, por = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0, avs_write = 1'b0, pix_valid = 1'b0;
    logic [31:0] avs_writedata = 32'h0, rdata, q;
    clvo_pixel_t pix = '0;
    logic link_clk, pix_ready, waitreq;
    logic [6:0] pclk_mhz;
    clvo_config_t cfg;
    clvo_bayer_t bayer;
    logic [159:0] lanes;
    clvo_sync_t sync;
    logic [15:0] capture, rnd = 16'hBF97;           // lfsr seed 49047
    logic [15:0] smp [10];                          // samples of one group
    logic [3:0] cur_l, l;                           // lanes in force, lanes asked
    logic [6:0] cur_c, c;
    logic [1:0] cur_b, m;                           // {mirror_h, mirror_v}
    logic [4:0] dep;                                // sample width in force
    int n_mismatch = 0, n_compared = 0;
    logic [3:0] lane_tbl [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hA};
    logic [6:0] clk_tbl [3] = '{CLK_45, CLK_65, CLK_85};
    logic [4:0] dep_tbl [4] = '{5'h08, 5'h0A, 5'h0C, 5'h10};
    logic [31:0] bad_tbl [2] = '{32'h0000_0555, 32'h0000_0321};  // lanes 5; clock 50 MHz
    always #5 clock_in = ~clock_in;
    clvo_link_out u_dut (.clock_in(clock_in), .reset_in(reset_in), .power_on_reset_in(por),
        .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .pix_valid_in(pix_valid), .pix_in(pix), .pix_ready_out(pix_ready),
        .link_clk_in(link_clk), .pclk_mhz_out(pclk_mhz), .link_config_out(cfg), .bayer_phase_out(bayer),
        .lane_data_out(lanes), .link_sync_out(sync));
    clvo_grabber_model u_grab (.lane_data_in(lanes), .link_sync_in(sync), .link_clk_out(link_clk),
        .capture_out(capture));
    ////////////////////////////////////////////////////////////////////////
    // expectation helpers, independent of the design's own functions
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function automatic logic [1:0] cfg_of(input logic [3:0] n);
        return (n < 4'h4) ? 2'h0 : (n == 4'h4) ? 2'h1 : (n == 4'h8) ? 2'h2 : 2'h3;
    endfunction : cfg_of
    function automatic logic depth_ok(input logic [4:0] d, input logic [3:0] n);
        if (d == 5'h08) return 1'b1;
        if (d != 5'h10) return (n == 4'h1) || (n == 4'h2) || (n == 4'h4);
        return n == 4'h1;
    endfunction : depth_ok
    // scale, saturate, drop low bits without wide range, then right-align
    function automatic logic [15:0] fmt(input logic [15:0] s, input logic [3:0] n, input logic [4:0] d);
        logic [17:0] t;
        t = (n >= 4'h8) ? {s, 2'b00} : {2'b00, s};
        if (t > 18'h0FFFF) t = 18'h0FFFF;
        if (d == 5'h10) t[3:0] = 4'h0;
        return t[15:0] >> (16 - d);
    endfunction : fmt
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // one avalon transfer: hold until waitrequest is seen low at an edge
    // waitrequest and readdata are read while settled, just before the edge that counts
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        logic w;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do begin
            @(negedge clock_in);
            w = waitreq;
            r = rdata;
            @(posedge clock_in);
            n++;
        end while (w !== 1'b0 && n < 50);
        if (n >= 50) n_mismatch++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock_in);
    endtask : bus
    task automatic restart(input logic first);
        if (first) por <= 1'b1;
        else reset_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        por <= 1'b0;
        reset_in <= 1'b0;
        @(posedge clock_in);
        dep = 5'h08;
    endtask : restart
    // status word against the settings in force
    task automatic check_status();
        bus(1'b0, OFS_STATUS, 32'h0, q);
        check(q[3:0], cur_l);
        check(q[10:4], cur_c);
        check(q[STAT_CFG_LSB +: 2], cfg_of(cur_l));
        check(q[STAT_BAYER_LSB +: 2], cur_b);
    endtask : check_status
    // fill one lane group with random samples and wait until it is out
    task automatic send_group();
        int n;
        logic w;
        for (int k = 0; k < cur_l; k++) begin
            rnd = lfsr(rnd);
            smp[k] = rnd;
            pix.sample <= rnd;
            pix.sof <= (k == 0);
            pix.eol <= (k == cur_l - 1);
            pix_valid <= 1'b1;
            n = 0;
            do begin
                @(negedge clock_in);
                w = pix_ready;
                @(posedge clock_in);
                n++;
            end while (w !== 1'b1 && n < 50);
            if (n >= 50) n_mismatch++;
        end
        pix_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while (pix_ready !== 1'b1 && n < 50);
        @(posedge clock_in);
        if (n >= 50) n_mismatch++;
    endtask : send_group
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sweep needs well under 20k cycles
    initial begin
        #400000;
        n_mismatch++;
        summarize();
    end
    initial begin
        restart(1'b1);
        {cur_l, cur_c, cur_b} = {4'h1, CLK_85, 2'b00};
        check_status();
        bus(1'b0, OFS_FORMAT, 32'h0, q);
        check(q[4:0], 5'h08);
        $display("defaults done");
        for (int i = 0; i < 6; i++) begin
            {l, c, m} = {lane_tbl[i], clk_tbl[i % 3], 2'(i)};
            bus(1'b1, OFS_SETUP, {18'h0, m[0], m[1], 1'b0, c, l}, q);
            bus(1'b0, OFS_SETUP, 32'h0, q);
            check(q[13:0], {m[0], m[1], 1'b0, c, l});
            check_status();  // nothing applied before restart
            restart(1'b0);
            {cur_l, cur_c, cur_b} = {l, c, m};
            check_status();
            check(pclk_mhz, c);
            check(cfg, cfg_of(l));
            check(bayer, m);
            foreach (dep_tbl[j]) begin
                bus(1'b1, OFS_FORMAT, {27'h0, dep_tbl[j]}, q);
                if (depth_ok(dep_tbl[j], l)) dep = dep_tbl[j];
                bus(1'b0, OFS_FORMAT, 32'h0, q);
                check(q[4:0], dep);
            end
            send_group();
            check(lanes[15:0], fmt(smp[0], l, dep));
            check(lanes[16*(l-1) +: 16], fmt(smp[l-1], l, dep));
            @(posedge link_clk);
            @(posedge clock_in);
            check(capture, fmt(smp[0], l, dep));
            $display("lanes %0d done", l);
        end
        foreach (bad_tbl[j]) begin
            bus(1'b1, OFS_SETUP, bad_tbl[j], q);
            restart(1'b0);
            check_status();
        end
        bus(1'b0, 4'hC, 32'h0, q);
        check(q, 32'h0);
        $display("refusals done");
        summarize();
    end
endmodule : camera_link_video_output_config_bench
